// >>> core/tcd_dma.sv
// Two-channel cycle-steal transfer engine sharing the CPU data bus
`timescale 1ns/1ps
`default_nettype none
module tcd_dma
	import tcd_pkg::*;
(
	input wire logic clk_i, // Bus clock, 25 MHz
	input wire logic reset_i, // Synchronous reset
	input wire logic ext_irq_pin_zero_i, // External pin for factor 0
	input wire logic ext_irq_pin_one_i, // External pin for factor 1
	input wire logic [13:0] periph_irq_i, // Peripheral interrupt levels, same clock
	input wire logic [NUM_CH-1:0] enable_wr_i, // Write pulse to enable bit
	input wire logic [NUM_CH-1:0] enable_val_i, // Value written to enable bit
	input wire logic [NUM_CH-1:0] sw_req_i, // Software request bit written one
	input wire logic [NUM_CH-1:0] req_clr_i, // Software writes zero to request bit
	input wire logic [NUM_CH-1:0] unit_size_select_i, // One bytes, zero words
	input wire logic [NUM_CH-1:0] repeat_i, // Repeat transfer mode
	input wire logic [2*NUM_CH-1:0] dir_i, // Per channel direction code
	input wire logic [2*SRC_W-1:0] factor_sel_i, // Per channel factor select
	input wire logic [NUM_CH-1:0] src_wr_i, // Source pointer write strobe
	input wire logic [NUM_CH-1:0] dst_wr_i, // Destination pointer write strobe
	input wire logic [NUM_CH-1:0] rld_wr_i, // Counter reload write strobe
	input wire logic [ADDR_W-1:0] wr_data_i, // Pointer or reload write data
	input wire logic [1:0] wait_area_i, // Software wait on internal memory
	output logic [2*ADDR_W-1:0] src_rd_o, // Source pointer read view
	output logic [2*ADDR_W-1:0] dst_rd_o, // Destination pointer read view
	output logic [2*CNT_W-1:0] cnt_o, // Working transfer counter
	output logic [NUM_CH-1:0] enable_o, // Enable bits
	output logic [NUM_CH-1:0] req_o, // Request bits
	output logic [NUM_CH-1:0] irq_o, // Underflow interrupt pulse
	input wire logic cpu_boundary_i, // CPU at bus-cycle boundary
	output logic bus_own_o, // Engine owns bus, CPU stalls
	output logic [ADDR_W-1:0] bus_addr_o, // Bus address
	output logic bus_rd_o, // Read strobe
	output logic bus_wr_o, // Write strobe
	output logic bus_byte_o, // Byte access
	output logic [DATA_W-1:0] bus_wdata_o, // Write data
	input wire logic [DATA_W-1:0] bus_rdata_i // Read data
);
	typedef struct packed {
		logic [1:0] en;
		logic [1:0] fresh;
		logic [1:0][ADDR_W-1:0] src;
		logic [1:0][ADDR_W-1:0] dst;
		logic [1:0][ADDR_W-1:0] wptr;
		logic [1:0][CNT_W-1:0] cnt;
		logic [1:0][CNT_W-1:0] rld;
		logic [1:0] irq;
		tcd_state_t st;
		logic ch;
		logic half;
		logic [1:0] wt;
		logic gap_done;
		logic [ADDR_W-1:0] addr;
		logic rd;
		logic wr;
		logic byt;
		logic [DATA_W-1:0] data;
		logic [DATA_W-1:0] wd;
	} tcd_st_t;
	tcd_st_t s_reg, s_next;

	logic [1:0] ext_sync;
	logic [15:0] factors;
	logic [1:0] req;
	logic [1:0] take;

	tcd_sync #(.W(2)) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i({ext_irq_pin_one_i, ext_irq_pin_zero_i}),
		.q_o(ext_sync)
	);
	// Interrupt levels are only observed, never acknowledged
	assign factors = {periph_irq_i, ext_sync};

	for (genvar c = 0; c < NUM_CH; c++) begin : g_req
		tcd_req u_req (
			.clk_i(clk_i),
			.reset_i(reset_i),
			.sel_i(factor_sel_i[c*SRC_W +: SRC_W]),
			.factors_i(factors),
			.sw_req_i(sw_req_i[c]),
			.sw_clr_i(req_clr_i[c]),
			.take_i(take[c]),
			.req_o(req[c])
		);
	end

	function automatic logic [1:0] area_k(input logic [ADDR_W-1:0] a, input logic w);
		if (a <= SFR_TOP) begin
			area_k = J_SFR;
		end else if (w) begin
			area_k = J_WAIT;
		end else begin
			area_k = J_NOWAIT;
		end
	endfunction

	function automatic logic in_regs(input logic [ADDR_W-1:0] a);
		in_regs = (a >= REG_LO) && (a <= REG_HI);
	endfunction

	logic [ADDR_W-1:0] rd_a;
	logic [ADDR_W-1:0] wr_a;
	logic src_inc;
	logic dst_inc;
	logic odd_word;
	logic [CNT_W-1:0] cur_cnt;
	logic [ADDR_W-1:0] cur_ptr;
	logic pick;
	logic pick_ch;
	logic [ADDR_W-1:0] step;

	// Next-state bus set-up and per-cycle helpers
	logic [ADDR_W-1:0] nrd_a;
	logic [ADDR_W-1:0] nwr_a;
	logic n_odd;
	logic [7:0] lane_b;
	logic [7:0] out_b;
	logic [1:0] want;
	logic [1:0] restart;
	logic [1:0] rd_len;
	logic [1:0] wr_len;
	logic rd_last;
	logic wr_last;
	logic underflow;

	always_comb begin
		s_next = s_reg;
		take = 2'h0;
		// Interrupt is a one-cycle pulse
		s_next.irq = 2'h0;
		s_next.rd = 1'b0;
		s_next.wr = 1'b0;
		src_inc = (dir_i[s_reg.ch*2 +: 2] == DIR_SRC_INC);
		dst_inc = (dir_i[s_reg.ch*2 +: 2] == DIR_DST_INC);
		rd_a = src_inc ? s_reg.wptr[s_reg.ch] : s_reg.src[s_reg.ch];
		wr_a = dst_inc ? s_reg.wptr[s_reg.ch] : s_reg.dst[s_reg.ch];
		odd_word = ~unit_size_select_i[s_reg.ch] & (rd_a[0] | wr_a[0]);
		// Incrementing pointer advances by the unit size
		step = unit_size_select_i[s_reg.ch] ? 20'h00001 : 20'h00002;
		cur_cnt = s_reg.cnt[s_reg.ch];
		cur_ptr = s_reg.wptr[s_reg.ch];
		pick = 1'b0;
		pick_ch = 1'b0;
		// Requests of disabled channels stay pending until enabled or cleared
		want = req & s_reg.en;
		restart = enable_wr_i & enable_val_i;
		// Bytes ride on the lane picked by address bit zero
		lane_b = s_reg.addr[0] ? bus_rdata_i[15:8] : bus_rdata_i[7:0];
		rd_len = area_k(rd_a, wait_area_i[0]);
		wr_len = area_k(wr_a, wait_area_i[1]);
		rd_last = (s_reg.wt == rd_len - 2'h1);
		wr_last = (s_reg.wt == wr_len - 2'h1);
		// Count N gives N+1 units; underflow is the step below zero
		underflow = (cur_cnt == 16'h0000);
		// Register strobes; fixed pointers locked while enabled
		for (int c = 0; c < NUM_CH; c++) begin
			if (src_wr_i[c] && (dir_i[c*2 +: 2] == DIR_SRC_INC || !s_reg.en[c])) begin
				s_next.src[c] = wr_data_i;
			end
			if (dst_wr_i[c] && (dir_i[c*2 +: 2] == DIR_DST_INC || !s_reg.en[c])) begin
				s_next.dst[c] = wr_data_i;
			end
			if (rld_wr_i[c]) begin
				s_next.rld[c] = wr_data_i[CNT_W-1:0];
			end
			if (enable_wr_i[c]) begin
				s_next.en[c] = enable_val_i[c];
				s_next.fresh[c] = enable_val_i[c];
			end
		end
		case (s_reg.st)
			ST_IDLE: begin
				// Channel zero has precedence on simultaneous requests
				if (want[0]) begin
					pick = 1'b1;
				end else if (want[1]) begin
					pick = 1'b1;
					pick_ch = 1'b1;
				end
				if (pick) begin
					s_next.ch = pick_ch;
					s_next.st = ST_WAITB;
				end
			end

			ST_WAITB: begin
				// A channel switched off after selection gives up its unit
				if (!s_reg.en[s_reg.ch]) begin
					s_next.st = ST_IDLE;
				end else if (cpu_boundary_i) begin
					take[s_reg.ch] = 1'b1;
					if (s_reg.fresh[s_reg.ch]) begin
						// A restart written in this very cycle must survive
						s_next.fresh[s_reg.ch] = restart[s_reg.ch];
						s_next.wptr[s_reg.ch] = src_inc ? s_reg.src[s_reg.ch] : s_reg.dst[s_reg.ch];
						s_next.cnt[s_reg.ch] = s_reg.rld[s_reg.ch];
					end
					s_next.half = 1'b0;
					s_next.wt = 2'h0;
					s_next.st = ST_READ;
				end
			end

			ST_READ: begin
				// Each access holds for area_k bus clocks; strobe and address already stand
				if (rd_last) begin
					s_next.wt = 2'h0;
					if (!s_reg.byt) begin
						s_next.data = bus_rdata_i;
					end else if (!s_reg.half) begin
						s_next.data[7:0] = lane_b;
					end else begin
						s_next.data[15:8] = lane_b;
					end
					if (odd_word && !s_reg.half) begin
						s_next.half = 1'b1;
					end else begin
						s_next.half = 1'b0;
						s_next.st = ST_WRITE;
					end
				end else begin
					s_next.wt = s_reg.wt + 2'h1;
				end
			end

			ST_WRITE: begin
				// Pointer and counter advance only after the last write of a unit
				if (wr_last) begin
					s_next.wt = 2'h0;
					if (odd_word && !s_reg.half) begin
						s_next.half = 1'b1;
					end else begin
						s_next.half = 1'b0;
						s_next.st = ST_GAP;
						s_next.gap_done = 1'b0;
						if (src_inc || dst_inc) begin
							s_next.wptr[s_reg.ch] = cur_ptr + step;
						end
						s_next.cnt[s_reg.ch] = cur_cnt - 16'h0001;
						if (underflow) begin
							s_next.irq[s_reg.ch] = 1'b1;
							if (repeat_i[s_reg.ch]) begin
								s_next.cnt[s_reg.ch] = s_reg.rld[s_reg.ch];
							end else if (!restart[s_reg.ch]) begin
								s_next.en[s_reg.ch] = 1'b0;
							end
						end
					end
				end else begin
					s_next.wt = s_reg.wt + 2'h1;
				end
			end

			ST_GAP: begin
				// Bus returns to the CPU for one access before the next unit
				if (s_reg.gap_done && cpu_boundary_i) begin
					s_next.st = ST_IDLE;
				end else if (cpu_boundary_i) begin
					s_next.gap_done = 1'b1;
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase

		// Bus controls are registered, so they are set up for the state being entered;
		// strobe, address and state then stay in step and read data is valid in the read state
		nrd_a = src_inc ? s_next.wptr[s_reg.ch] : s_next.src[s_reg.ch];
		nwr_a = dst_inc ? s_next.wptr[s_reg.ch] : s_next.dst[s_reg.ch];
		n_odd = ~unit_size_select_i[s_reg.ch] & (nrd_a[0] | nwr_a[0]);
		s_next.byt = unit_size_select_i[s_reg.ch] | n_odd;
		// A byte is copied onto both lanes so either address parity finds it
		out_b = s_next.half ? s_next.data[15:8] : s_next.data[7:0];
		s_next.wd = s_next.byt ? {out_b, out_b} : s_next.data;

		if (s_next.st == ST_READ) begin
			s_next.addr = nrd_a + {19'h0, s_next.half};
			s_next.rd = ~in_regs(s_next.addr);
		end else if (s_next.st == ST_WRITE) begin
			s_next.addr = nwr_a + {19'h0, s_next.half};
			s_next.wr = ~in_regs(s_next.addr);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Bus is held from boundary through destination write
	assign bus_own_o = (s_reg.st == ST_READ) || (s_reg.st == ST_WRITE);
	assign bus_addr_o = s_reg.addr;
	assign bus_rd_o = s_reg.rd;
	assign bus_wr_o = s_reg.wr;
	assign bus_byte_o = s_reg.byt;
	assign bus_wdata_o = s_reg.wd;
	// Read views follow the registers with no added delay
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			src_rd_o[c*ADDR_W +: ADDR_W] = (s_reg.en[c] && dir_i[c*2 +: 2] == DIR_SRC_INC) ?
				s_reg.wptr[c] : s_reg.src[c];
			dst_rd_o[c*ADDR_W +: ADDR_W] = (s_reg.en[c] && dir_i[c*2 +: 2] == DIR_DST_INC) ?
				s_reg.wptr[c] : s_reg.dst[c];
			cnt_o[c*CNT_W +: CNT_W] = s_reg.cnt[c];
		end
	end
	assign enable_o = s_reg.en;
	assign req_o = req;
	assign irq_o = s_reg.irq;
endmodule // tcd_dma
`default_nettype wire

// >>> core/tcd_pkg.sv
// Shared constants and types for the two-channel cycle-steal transfer engine
package tcd_pkg;
	localparam int ADDR_W = 20;
	localparam int CNT_W = 16;
	localparam int DATA_W = 16;
	localparam int NUM_CH = 2;
	localparam int SRC_W = 4;
	// Own register window that transfers may not touch
	localparam logic [19:0] REG_LO = 20'h00020;
	localparam logic [19:0] REG_HI = 20'h0003F;
	// Bus clocks per access by area
	localparam logic [1:0] J_NOWAIT = 2'h1;
	localparam logic [1:0] J_WAIT = 2'h2;
	localparam logic [1:0] J_SFR = 2'h3;
	localparam logic [19:0] SFR_TOP = 20'h003FF;
	localparam logic [1:0] DIR_SRC_INC = 2'h0;
	localparam logic [1:0] DIR_DST_INC = 2'h1;
	localparam logic [1:0] DIR_FIXED = 2'h2;
	typedef enum logic [2:0] {ST_IDLE, ST_WAITB, ST_READ, ST_WRITE, ST_GAP} tcd_state_t;
endpackage : tcd_pkg

// >>> core/tcd_req.sv
// Per-channel request flag with edge capture and software clear
`timescale 1ns/1ps
`default_nettype none
module tcd_req
	import tcd_pkg::*;
(
	input wire logic clk_i, // Bus clock
	input wire logic reset_i, // Synchronous reset
	input wire logic [SRC_W-1:0] sel_i, // Factor select
	input wire logic [15:0] factors_i, // Synchronised factor levels
	input wire logic sw_req_i, // Software request pulse
	input wire logic sw_clr_i, // Software clear pulse
	input wire logic take_i, // Transfer about to start
	output logic req_o // Request flag
);
	typedef struct packed {
		logic prev;
		logic req;
	} tcd_rq_t;
	tcd_rq_t s_reg, s_next;
	logic rise;
	always_comb begin
		s_next = s_reg;
		rise = factors_i[sel_i] & ~s_reg.prev;
		s_next.prev = factors_i[sel_i];
		if (take_i || sw_clr_i) begin
			s_next.req = 1'b0;
		end
		// Set wins over any clear in the same cycle
		if (rise || sw_req_i) begin
			s_next.req = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign req_o = s_reg.req;
endmodule // tcd_req
`default_nettype wire

// >>> core/tcd_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module tcd_sync #(
	parameter int W = 2
) (
	input wire logic clk_i, // Bus clock
	input wire logic reset_i, // Synchronous reset
	input wire logic [W-1:0] d_i, // Asynchronous levels
	output logic [W-1:0] q_o // Synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tcd_sy_t;
	tcd_sy_t s_reg, s_next;
	always_comb begin
		s_next.s1 = d_i;
		s_next.s2 = s_reg.s1;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign q_o = s_reg.s2;
endmodule // tcd_sync
`default_nettype wire

// >>> test/tcd_dma_asserts.sv
// Port-level property checks for the transfer engine
`timescale 1ns/1ps
`default_nettype none
module tcd_dma_asserts
	import tcd_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic reset_i, // Reset
	input wire logic [NUM_CH-1:0] enable_wr_i, // Enable write
	input wire logic [NUM_CH-1:0] enable_val_i, // Enable value
	input wire logic [NUM_CH-1:0] repeat_i, // Repeat mode
	input wire logic cpu_boundary_i, // CPU boundary
	input wire logic [NUM_CH-1:0] enable_o, // Enables
	input wire logic [NUM_CH-1:0] irq_o, // Underflow
	input wire logic bus_own_o, // Bus owned
	input wire logic [ADDR_W-1:0] bus_addr_o, // Address
	input wire logic bus_rd_o, // Read
	input wire logic bus_wr_o, // Write
	input wire logic bus_byte_o // Byte
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_rd_wr_excl: assert property (!(bus_rd_o && bus_wr_o)) else $error("read and write together");
	a_reg_window: assert property ((bus_rd_o || bus_wr_o) |-> (bus_addr_o < REG_LO || bus_addr_o > REG_HI))
		else $error("own window accessed");
	a_strobe_own: assert property ((bus_rd_o || bus_wr_o) |-> bus_own_o) else $error("strobe without bus");
	a_take_bound: assert property ($rose(bus_own_o) |-> $past(cpu_boundary_i)) else $error("bus taken mid cycle");
	a_cpu_gap: assert property ($fell(bus_own_o) |-> !bus_own_o [*2]) else $error("no CPU slot");
	a_irq_pulse: assert property (irq_o[0] |=> !irq_o[0]) else $error("irq too long");
	a_irq_wr: assert property (irq_o != 2'h0 |-> $past(bus_wr_o) || $past(bus_wr_o, 2)) else $error("irq without write");
	a_single_off: assert property (irq_o[0] && !repeat_i[0] && !enable_wr_i[0] |-> ##[0:2] !enable_o[0])
		else $error("single mode stays on");
	a_repeat_on: assert property (irq_o[0] && repeat_i[0] && !enable_wr_i[0] |=> enable_o[0])
		else $error("repeat mode dropped");
	a_enable_src: assert property ($rose(enable_o[0]) |-> $past(enable_wr_i[0] && enable_val_i[0]))
		else $error("enable without write");
	c_irq: cover property (irq_o[0] && repeat_i[0]);
	c_byte: cover property (bus_wr_o && bus_byte_o);
	c_both: cover property (irq_o[1]);
endmodule // tcd_dma_asserts
bind tcd_dma tcd_dma_asserts u_chk (.clk_i, .reset_i, .enable_wr_i, .enable_val_i, .repeat_i, .cpu_boundary_i,
	.enable_o, .irq_o, .bus_own_o, .bus_addr_o, .bus_rd_o, .bus_wr_o, .bus_byte_o);
`default_nettype wire

// >>> test/tcd_cpu_model.sv
// CPU side model: shared byte memory and bus-cycle boundaries
`timescale 1ns/1ps
`default_nettype none
module tcd_cpu_model
	import tcd_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic slow_i, // Sparse boundaries
	input wire logic [ADDR_W-1:0] addr_i, // Address
	input wire logic rd_i, // Read
	input wire logic wr_i, // Write
	input wire logic byte_i, // Byte access
	input wire logic [DATA_W-1:0] wdata_i, // Write data
	output logic bnd_o, // CPU boundary
	output logic [DATA_W-1:0] rdata_o // Read data
);
	logic [7:0] mem [0:1023];
	logic [1:0] ph = 2'h0;
	logic [DATA_W-1:0] last = 16'h0000;
	initial begin
		for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h5A;
	end
	// Long CPU instructions give a boundary only every third clock
	assign bnd_o = !slow_i || ph == 2'h0;
	// An idle bus shows the inverse of the last value, never a held copy
	assign rdata_o = rd_i ? {mem[{addr_i[9:1], 1'b1}], mem[{addr_i[9:1], 1'b0}]} : ~last;
	always @(posedge clk_i) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		if (rd_i) last <= rdata_o;
		if (wr_i && (!byte_i || !addr_i[0])) mem[{addr_i[9:1], 1'b0}] <= wdata_i[7:0];
		if (wr_i && (!byte_i || addr_i[0])) mem[{addr_i[9:1], 1'b1}] <= wdata_i[15:8];
	end
endmodule // tcd_cpu_model
`default_nettype wire

// >>> test/tcd_dma_tb_top.sv
// Self-checking bench for the two-channel transfer engine
`timescale 1ns/1ps
`default_nettype none
module tcd_dma_tb_top;
	import tcd_pkg::*;
	logic clk_i = 1'b0, reset_i = 1'b1, slow = 1'b0, cpu_boundary_i, bus_own_o, bus_rd_o, bus_wr_o, bus_byte_o;
	logic ext_irq_pin_zero_i = 1'b0, ext_irq_pin_one_i = 1'b0, pwr = 1'b0;
	logic [NUM_CH-1:0] enable_wr_i = '0, enable_val_i = '0, sw_req_i = '0, req_clr_i = '0, unit_size_select_i = '0;
	logic [NUM_CH-1:0] repeat_i = '0, src_wr_i = '0, dst_wr_i = '0, rld_wr_i = '0, enable_o, req_o, irq_o;
	logic [3:0] dir_i = '0;
	logic [7:0] factor_sel_i = 8'h20;
	logic [13:0] periph_irq_i = '0;
	logic [1:0] wait_area_i = '0;
	logic [ADDR_W-1:0] wr_data_i = '0, bus_addr_o, paddr = '0, first_rd = '0;
	logic [2*ADDR_W-1:0] src_rd_o, dst_rd_o;
	logic [2*CNT_W-1:0] cnt_o;
	logic [DATA_W-1:0] bus_wdata_o, bus_rdata_i;
	int mismatches = 0, n_compared = 0, wr_cnt = 0, irq_cnt = 0, irq1_cnt = 0;
	tcd_dma uut (.clk_i, .reset_i, .ext_irq_pin_zero_i, .ext_irq_pin_one_i, .periph_irq_i, .enable_wr_i,
		.enable_val_i, .sw_req_i, .req_clr_i, .unit_size_select_i, .repeat_i, .dir_i, .factor_sel_i, .src_wr_i,
		.dst_wr_i, .rld_wr_i, .wr_data_i, .wait_area_i, .src_rd_o, .dst_rd_o, .cnt_o, .enable_o, .req_o, .irq_o,
		.cpu_boundary_i, .bus_own_o, .bus_addr_o, .bus_rd_o, .bus_wr_o, .bus_byte_o, .bus_wdata_o, .bus_rdata_i);
	tcd_cpu_model u_cpu (.clk_i(clk_i), .slow_i(slow), .addr_i(bus_addr_o), .rd_i(bus_rd_o), .wr_i(bus_wr_o),
		.byte_i(bus_byte_o), .wdata_i(bus_wdata_o), .bnd_o(cpu_boundary_i), .rdata_o(bus_rdata_i));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// Each new write address counts as one write access
	always @(posedge clk_i) begin
		if (bus_wr_o && (!pwr || bus_addr_o != paddr)) wr_cnt++;
		if (irq_o[0]) irq_cnt++;
		if (irq_o[1]) irq1_cnt++;
		if (bus_rd_o && first_rd == '1) first_rd <= bus_addr_o;
		pwr <= bus_wr_o;
		paddr <= bus_addr_o;
	end
	task automatic end_sim();
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Kinds: 0 source, 1 destination, 2 reload, 3 enable, 4 request, 5 request clear
	task automatic wr(input int k, input logic [1:0] ch, input logic [19:0] d);
		@(posedge clk_i);
		wr_data_i <= d;
		enable_val_i <= d[1:0];
		case (k)
			0: src_wr_i <= ch;
			1: dst_wr_i <= ch;
			2: rld_wr_i <= ch;
			3: enable_wr_i <= ch;
			4: sw_req_i <= ch;
			default: req_clr_i <= ch;
		endcase
		@(posedge clk_i);
		{src_wr_i, dst_wr_i, rld_wr_i, enable_wr_i, sw_req_i, req_clr_i} <= '0;
		@(negedge clk_i);
	endtask
	task automatic unit(input logic [1:0] ch, input int nwr);
		int n;
		n = wr_cnt + nwr;
		wr(4, ch, '0);
		for (int i = 0; i < 300 && !(wr_cnt >= n && !bus_own_o); i++) @(negedge clk_i);
		repeat (4) @(negedge clk_i);
		chk("write count", wr_cnt, n);
	endtask
	initial begin
		// Over ten times the roughly 165 cycles that the scenarios need
		repeat (2000) @(posedge clk_i);
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		slow <= 1'b1;
		unit_size_select_i <= 2'h1;
		wr(0, 2'h1, 20'h00400);
		wr(1, 2'h1, 20'h00500);
		wr(2, 2'h1, 20'h00002);
		wr(3, 2'h1, 20'h00001);
		unit(2'h1, 1);
		unit(2'h1, 1);
		chk("working src", src_rd_o[19:0], 20'h00402);
		chk("count", cnt_o[15:0], 16'h0000);
		wr(3, 2'h1, 20'h00001);
		unit(2'h1, 1);
		chk("restart src", src_rd_o[19:0], 20'h00401);
		chk("reload count", cnt_o[15:0], 16'h0001);
		unit(2'h1, 1);
		unit(2'h1, 1);
		chk("single off", enable_o[0], 1'b0);
		chk("irq count", irq_cnt, 1);
		chk("last byte", u_cpu.mem[10'h100], 8'h02 ^ 8'h5A);
		chk("idle src view", src_rd_o[19:0], 20'h00400);
		@(posedge clk_i);
		slow <= 1'b0;
		unit_size_select_i <= 2'h0;
		repeat_i <= 2'h1;
		dir_i <= {2'h0, DIR_DST_INC};
		wait_area_i <= 2'h3;
		wr(0, 2'h1, 20'h00401);
		wr(1, 2'h1, 20'h00601);
		wr(2, 2'h1, 20'h00000);
		wr(3, 2'h1, 20'h00001);
		unit(2'h1, 2);
		chk("word low", u_cpu.mem[10'h201], 8'h01 ^ 8'h5A);
		chk("word high", u_cpu.mem[10'h202], 8'h02 ^ 8'h5A);
		chk("working dst", dst_rd_o[19:0], 20'h00603);
		wr(0, 2'h1, 20'h00777);
		chk("fixed locked", src_rd_o[19:0], 20'h00401);
		unit(2'h1, 2);
		chk("repeat on", enable_o[0], 1'b1);
		chk("repeat irq", irq_cnt, 3);
		wr(3, 2'h1, 20'h00000);
		chk("repeat off", enable_o[0], 1'b0);
		@(posedge clk_i);
		repeat_i <= 2'h0;
		unit_size_select_i <= 2'h3;
		dir_i <= {DIR_FIXED, DIR_SRC_INC};
		wait_area_i <= 2'h0;
		wr(0, 2'h1, 20'h00410);
		wr(0, 2'h2, 20'h00030);
		wr(1, 2'h1, 20'h00510);
		wr(1, 2'h2, 20'h00520);
		wr(2, 2'h3, 20'h00000);
		wr(3, 2'h3, 20'h00003);
		first_rd <= '1;
		unit(2'h3, 2);
		chk("first served", first_rd, 20'h00410);
		chk("both off", enable_o, 2'h0);
		chk("irq one count", irq1_cnt, 1);
		chk("fixed dest", u_cpu.mem[10'h110], 8'h10 ^ 8'h5A);
		wr(4, 2'h2, '0);
		chk("req idle", req_o, 2'h2);
		wr(5, 2'h2, '0);
		chk("req clear", req_o, 2'h0);
		@(posedge clk_i);
		periph_irq_i <= 14'h0001;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("factor req", req_o, 2'h2);
		@(posedge clk_i);
		ext_irq_pin_zero_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk("pin req", req_o, 2'h3);
		end_sim();
	end
endmodule // tcd_dma_tb_top
`default_nettype wire
